// ===== rtl/sar_adc_sequencer.sv
// Register file, start control, channel decode and interrupt of the converter.
// Assumes a same-clock register master and an asynchronous analog comparator.
// Function
// - Conversion starts only when software writes one to the start bit.
// - Without sample-and-hold, 49 cycles at 8 bits, 59 at 10 bits.
// - With sample-and-hold, 28 cycles at 8 bits, 33 at 10 bits.
// - Resolution bit picks 8 or 10 bits, setting width and length.
// - Input above reference saturates result to all ones.
// - Three channel bits plus group bit pick inputs; group one uses codes 4-7.
// - Twelve analog inputs, exactly one converted at a time.
// - Each completed conversion is written to the result register.
// - One-shot converts once, clears start bit, raises completion interrupt.
// - Repeat converts until start bit cleared, no interrupt.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`default_nettype none
module sar_adc_sequencer (
  input  wire logic        ref_clk_in,   // 10 MHz system clock
  input  wire logic        srst_in,      // sync reset, active high
  input  wire logic [2:0]  addr_in,      // register address
  input  wire logic [15:0] wdata_in,     // write data
  input  wire logic        wr_in,        // write strobe
  input  wire logic        rd_in,        // read strobe
  output logic      [15:0] rdata_out,    // read data, cycle after rd_in
  input  wire logic        osc_in,       // fast_onchip_osc_clock pin
  input  wire logic        cmp_in,       // analog comparator, async
  output logic      [3:0]  channel_out,  // analog_inputs mux select
  output logic             ref_conn_out, // reference ladder connect
  output logic             sample_out,   // sample phase
  output logic      [9:0]  trial_out,    // ladder trial code
  output logic             irq_out       // level interrupt
);
  typedef struct packed {
    logic [2:0]  ch;
    logic        rpt;
    logic [1:0]  cks;
    logic        start;
    logic        grp;
    logic        res10;
    logic        vref;
    logic        shold;
    logic [9:0]  result;
    logic        stat;
    logic        mask;
    logic [15:0] rdata;
    logic        c1;
    logic        c2;
  } sar_regs_t;
  sar_regs_t st_ff, nxt_st;

  logic       tick;
  logic       busy;
  logic       done;
  logic [9:0] core_res;
  logic       wr0;

  sar_clkdiv u_div (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .sel_in     (st_ff.cks),
    .osc_in     (osc_in),
    .tick_out   (tick)
  );

  sar_core u_core (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .tick_in    (tick),
    .go_in      (st_ff.start),
    .res10_in   (st_ff.res10),
    .shold_in   (st_ff.shold),
    .cmp_in     (st_ff.c2),
    .busy_out   (busy),
    .sample_out (sample_out),
    .done_out   (done),
    .trial_out  (trial_out),
    .result_out (core_res)
  );

  assign wr0 = wr_in && (addr_in == sar_pkg::OFF_CTRL0);

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.c1 = cmp_in;
    nxt_st.c2 = st_ff.c1;
    // Hardware clear first so a same-cycle software set wins
    if (done && !st_ff.rpt) begin
      nxt_st.start = 1'b0;
    end
    if (wr_in) begin
      case (addr_in)
        sar_pkg::OFF_CTRL0: begin
          nxt_st.ch    = wdata_in[sar_pkg::C0_CH_LSB +: 3];
          nxt_st.rpt   = wdata_in[sar_pkg::C0_RPT];
          nxt_st.cks   = wdata_in[sar_pkg::C0_CKS_LSB +: 2];
          nxt_st.start = wdata_in[sar_pkg::C0_START];
        end
        sar_pkg::OFF_CTRL1: begin
          nxt_st.grp   = wdata_in[sar_pkg::C1_GRP];
          nxt_st.res10 = wdata_in[sar_pkg::C1_RES10];
          nxt_st.vref  = wdata_in[sar_pkg::C1_VREF];
        end
        sar_pkg::OFF_CTRL2: nxt_st.shold = wdata_in[sar_pkg::C2_SHOLD];
        sar_pkg::OFF_STAT: begin
          if (wdata_in[sar_pkg::ST_DONE]) begin
            nxt_st.stat = 1'b0;
          end
        end
        sar_pkg::OFF_MASK: nxt_st.mask = wdata_in[sar_pkg::ST_DONE];
        default: nxt_st.mask = st_ff.mask;
      endcase
    end
    // A result finishing after an abort request is still complete
    if (done) begin
      nxt_st.result = st_ff.res10 ? core_res : {2'b00, core_res[7:0]};
      if (!st_ff.rpt) begin
        nxt_st.stat = 1'b1;
      end
    end
    nxt_st.rdata = 16'h0000;
    if (rd_in) begin
      case (addr_in)
        sar_pkg::OFF_CTRL0: begin
          nxt_st.rdata[sar_pkg::C0_CH_LSB +: 3]  = st_ff.ch;
          nxt_st.rdata[sar_pkg::C0_RPT]          = st_ff.rpt;
          nxt_st.rdata[sar_pkg::C0_CKS_LSB +: 2] = st_ff.cks;
          nxt_st.rdata[sar_pkg::C0_START]        = st_ff.start;
        end
        sar_pkg::OFF_CTRL1: begin
          nxt_st.rdata[sar_pkg::C1_GRP]   = st_ff.grp;
          nxt_st.rdata[sar_pkg::C1_RES10] = st_ff.res10;
          nxt_st.rdata[sar_pkg::C1_VREF]  = st_ff.vref;
        end
        sar_pkg::OFF_CTRL2:  nxt_st.rdata[sar_pkg::C2_SHOLD] = st_ff.shold;
        sar_pkg::OFF_RESULT: nxt_st.rdata[9:0] = st_ff.result;
        sar_pkg::OFF_STAT:   nxt_st.rdata[sar_pkg::ST_DONE] = st_ff.stat;
        sar_pkg::OFF_MASK:   nxt_st.rdata[sar_pkg::ST_DONE] = st_ff.mask;
        default:             nxt_st.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      st_ff        <= '0;
      st_ff.result <= sar_pkg::RST_RESULT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Group one only reaches inputs 8-11; low codes are undefined by software
  assign channel_out  = st_ff.grp ? (sar_pkg::BASE_HIGH_GRP | {2'b00, st_ff.ch[1:0]})
                                  : {1'b0, st_ff.ch};
  assign ref_conn_out = st_ff.vref;
  assign rdata_out    = st_ff.rdata;
  assign irq_out      = st_ff.stat & st_ff.mask;

  // Helper logic for checks
  logic [5:0] h_ticks_ff;
  logic       h_sat_ff;
  logic [5:0] h_exp;
  logic       clr_stat;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      h_ticks_ff <= 6'd0;
      h_sat_ff   <= 1'b0;
    end else if (!busy) begin
      h_ticks_ff <= done ? h_ticks_ff : 6'd0;
      h_sat_ff   <= done ? h_sat_ff : 1'b1;
    end else if (tick) begin
      h_ticks_ff <= h_ticks_ff + 6'd1;
      h_sat_ff   <= h_sat_ff & st_ff.c2;
    end
  end
  assign h_exp = st_ff.res10 ? (st_ff.shold ? sar_pkg::CYC_10_SH : sar_pkg::CYC_10_NOSH)
                             : (st_ff.shold ? sar_pkg::CYC_8_SH : sar_pkg::CYC_8_NOSH);
  // Software clear of the done flag, for the status checks
  assign clr_stat = wr_in && (addr_in == sar_pkg::OFF_STAT) && wdata_in[sar_pkg::ST_DONE];

  // Checks see the core through its busy, done, sample, trial and result outputs
  a_start_by_sw: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    $rose(busy) |-> $past(st_ff.start))
    else $error("conversion began without start bit");

  a_start_runs: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    $rose(st_ff.start)
    |=> busy)
    else $error("start bit did not launch a conversion");

  a_idle_stays: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (!st_ff.start && !busy)
    |=> !busy)
    else $error("conversion began while start bit clear");

  a_len_plain: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (done && !st_ff.shold) |-> h_ticks_ff == h_exp)
    else $error("wrong conversion length without sample-and-hold");

  a_len_hold: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (done && st_ff.shold) |-> h_ticks_ff == h_exp)
    else $error("wrong conversion length with sample-and-hold");

  a_len_bound: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    busy
    |-> (h_ticks_ff < h_exp))
    else $error("conversion ran past its length");

  a_sample_first: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    $rose(busy)
    |-> sample_out)
    else $error("conversion did not open with sampling");

  a_sample_idle: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !busy
    |-> !sample_out)
    else $error("sampling while idle");

  a_trial_top: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !st_ff.res10
    |-> (trial_out[1:0] == 2'h0))
    else $error("8-bit trial code not on the top ladder taps");

  a_low_byte: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (done && !st_ff.res10) |=> st_ff.result[9:8] == 2'b00)
    else $error("upper result bits set in 8-bit mode");

  a_saturate: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (done && h_sat_ff) |=> st_ff.result == (st_ff.res10 ? sar_pkg::FULL_10 : sar_pkg::FULL_8))
    else $error("over-range input did not saturate");

  a_result_load: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (done && st_ff.res10) |=> st_ff.result == $past(core_res))
    else $error("result register not updated");

  a_result_quiet: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !done
    |=> $stable(st_ff.result))
    else $error("result changed without a completion");

  a_oneshot_end: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (done && !st_ff.rpt && !wr0) |=> (!st_ff.start && st_ff.stat))
    else $error("one-shot did not stop and flag");

  a_done_pulse: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    done
    |=> !done)
    else $error("completion pulse longer than one cycle");

  a_repeat_run: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (done && st_ff.rpt && st_ff.start && !wr0) |=> st_ff.start ##1 busy)
    else $error("repeat mode did not continue");

  a_repeat_noirq: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (done && st_ff.rpt && !st_ff.stat) |=> !st_ff.stat)
    else $error("repeat mode raised a flag");

  a_abort_hold: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (busy && !st_ff.start) |=> (!busy && !done && $stable(st_ff.result)))
    else $error("abort did not stop cleanly");

  a_chan_range: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    channel_out <= 4'hB)
    else $error("channel select out of range");

  a_chan_steady: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (busy && !wr_in)
    |=> $stable(channel_out))
    else $error("input selection moved during a conversion");

  a_stat_sticky: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (st_ff.stat && !clr_stat)
    |=> st_ff.stat)
    else $error("done flag dropped without a clear");

  a_stat_clear: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (clr_stat && !done)
    |=> !st_ff.stat)
    else $error("done flag not cleared by software");

  a_irq_level: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (done && !st_ff.rpt && st_ff.mask && !(wr_in && addr_in == sar_pkg::OFF_MASK))
    |=> irq_out)
    else $error("interrupt not raised");

  a_rdata_idle: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !$past(rd_in)
    |-> (rdata_out == 16'h0000))
    else $error("read data outside its cycle");

  // Main scenarios worth seeing at least once
  c_oneshot: cover property (@(posedge ref_clk_in) disable iff (srst_in) done && !st_ff.rpt);
  c_repeat: cover property (@(posedge ref_clk_in) disable iff (srst_in)
    done && st_ff.rpt ##[1:1000] done);
  c_abort: cover property (@(posedge ref_clk_in) disable iff (srst_in) busy && !st_ff.start);
  c_irq: cover property (@(posedge ref_clk_in) disable iff (srst_in) irq_out);
  c_saturate: cover property (@(posedge ref_clk_in) disable iff (srst_in) done && h_sat_ff);
endmodule : sar_adc_sequencer
`default_nettype wire

// ===== rtl/sar_pkg.sv
// Shared constants of the successive-approximation converter sequencer.
// Assumes a single 10 MHz clock and a plain address/strobe register port.
`default_nettype none
package sar_pkg;
  localparam logic [2:0] OFF_CTRL0  = 3'h0; // converter_control_first
  localparam logic [2:0] OFF_CTRL1  = 3'h1; // converter_control_second
  localparam logic [2:0] OFF_CTRL2  = 3'h2; // converter_control_third
  localparam logic [2:0] OFF_RESULT = 3'h3;
  localparam logic [2:0] OFF_STAT   = 3'h4;
  localparam logic [2:0] OFF_MASK   = 3'h5;
  // converter_control_first fields
  localparam int C0_CH_LSB  = 0;
  localparam int C0_RPT     = 3;
  localparam int C0_CKS_LSB = 4;
  localparam int C0_START   = 6;
  // converter_control_second fields
  localparam int C1_GRP     = 0;
  localparam int C1_RES10   = 3;
  localparam int C1_VREF    = 5;
  // converter_control_third field; status and mask done bit
  localparam int C2_SHOLD   = 0;
  localparam int ST_DONE    = 0;
  localparam logic [15:0] RST_CTRL  = 16'h0000;
  localparam logic [9:0]  RST_RESULT = 10'h000;
  localparam logic [3:0]  BASE_HIGH_GRP = 4'h8;
  // Conversion lengths in converter clock cycles
  localparam logic [5:0] CYC_8_NOSH  = 6'd49;
  localparam logic [5:0] CYC_10_NOSH = 6'd59;
  localparam logic [5:0] CYC_8_SH    = 6'd28;
  localparam logic [5:0] CYC_10_SH   = 6'd33;
  localparam logic [5:0] BITS_8  = 6'd8;
  localparam logic [5:0] BITS_10 = 6'd10;
  localparam logic [9:0] FULL_10 = 10'h3FF;
  localparam logic [9:0] FULL_8  = 10'h0FF;
  // Converter clock dividers from the system clock
  localparam logic [3:0] DIV_A = 4'h3;
  localparam logic [3:0] DIV_B = 4'h7;
  localparam logic [3:0] DIV_C = 4'hF;
endpackage : sar_pkg
`default_nettype wire

// ===== rtl/sar_clkdiv.sv
// Converter clock enable: divided system clock or synchronised oscillator.
// Assumes the oscillator pin is slower than a quarter of ref_clk_in.
`default_nettype none
module sar_clkdiv (
  input  wire logic       ref_clk_in, // system clock
  input  wire logic       srst_in,    // sync reset
  input  wire logic [1:0] sel_in,     // clock source select
  input  wire logic       osc_in,     // fast_onchip_osc_clock pin
  output logic            tick_out    // one-cycle converter clock enable
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       s1;
    logic       s2;
    logic       s3;
    logic       tick;
  } sar_div_t;
  sar_div_t st_ff, nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.s1   = osc_in;
    nxt_st.s2   = st_ff.s1;
    nxt_st.s3   = st_ff.s2;
    nxt_st.cnt  = st_ff.cnt + 4'h1;
    nxt_st.tick = 1'b0;
    case (sel_in)
      2'b00: nxt_st.tick = ((st_ff.cnt & sar_pkg::DIV_A) == sar_pkg::DIV_A);
      2'b01: nxt_st.tick = ((st_ff.cnt & sar_pkg::DIV_B) == sar_pkg::DIV_B);
      2'b10: nxt_st.tick = (st_ff.cnt == sar_pkg::DIV_C);
      2'b11: nxt_st.tick = st_ff.s2 & ~st_ff.s3;
      default: nxt_st.tick = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_out = st_ff.tick;
endmodule : sar_clkdiv
`default_nettype wire

// ===== rtl/sar_core.sv
// Successive-approximation step engine: sampling phase, then one bit per tick.
// Assumes the comparator answer settles within the spacing of two ticks.
`default_nettype none
module sar_core (
  input  wire logic       ref_clk_in, // system clock
  input  wire logic       srst_in,    // sync reset
  input  wire logic       tick_in,    // converter clock enable
  input  wire logic       go_in,      // start level, low aborts
  input  wire logic       res10_in,   // 10-bit resolution
  input  wire logic       shold_in,   // sample-and-hold enable
  input  wire logic       cmp_in,     // synchronised comparator, 1 = input at or above trial
  output logic            busy_out,   // conversion running
  output logic            sample_out, // sampling phase
  output logic            done_out,   // one-cycle completion pulse
  output logic [9:0]      trial_out,  // trial code to the ladder
  output logic [9:0]      result_out  // last result
);
  typedef struct packed {
    logic       busy;
    logic       done;
    logic [5:0] cnt;
    logic [9:0] sar;
    logic [9:0] res;
  } sar_core_t;
  sar_core_t st_ff, nxt_st;
  logic [5:0] total;
  logic [5:0] nbits;
  logic [5:0] bidx;
  logic       bitph;
  logic [9:0] trial;

  always_comb begin
    case ({res10_in, shold_in})
      2'b00: total = sar_pkg::CYC_8_NOSH;
      2'b10: total = sar_pkg::CYC_10_NOSH;
      2'b01: total = sar_pkg::CYC_8_SH;
      2'b11: total = sar_pkg::CYC_10_SH;
      default: total = sar_pkg::CYC_8_NOSH;
    endcase
    nbits = res10_in ? sar_pkg::BITS_10 : sar_pkg::BITS_8;
    bitph = st_ff.busy && (st_ff.cnt >= total - nbits);
    bidx  = total - 6'd1 - st_ff.cnt;
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (!go_in) begin
      nxt_st.busy = 1'b0;
    end else if (!st_ff.busy) begin
      if (!st_ff.done) begin
        nxt_st.busy = 1'b1;
        nxt_st.cnt  = '0;
        nxt_st.sar  = '0;
      end
    end else if (tick_in) begin
      nxt_st.cnt = st_ff.cnt + 6'd1;
      // Input above reference keeps every bit, so the code saturates
      if (bitph) begin
        nxt_st.sar[bidx[3:0]] = cmp_in;
      end
      if (st_ff.cnt == total - 6'd1) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
        nxt_st.res  = nxt_st.sar;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy_out   = st_ff.busy;
  assign done_out   = st_ff.done;
  assign result_out = st_ff.res;
  assign sample_out = st_ff.busy && !bitph;
  assign trial      = bitph ? (st_ff.sar | (10'h001 << bidx[3:0])) : st_ff.sar;
  // An 8-bit code drives the top taps of the 10-bit ladder, else it saturates early
  assign trial_out  = res10_in ? trial : {trial[7:0], 2'h0};
endmodule : sar_core
`default_nettype wire

// ===== verification/sar_analog_model.sv
// Analog sources behind the input multiplexer, seen through the comparator.
// Assumes the design synchronises cmp_out; this model answers at once.
`default_nettype none
module sar_analog_model (
  input  wire logic [3:0] channel_in, // selected analog input
  input  wire logic [9:0] trial_in,   // ladder trial code
  output logic            cmp_out     // 1 = input at or above trial
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] level;
  // Only the selected input reaches the comparator; input 11 is above reference
  always_comb begin
    level = (channel_in == 4'hB) ? 11'h400 : {1'b0, channel_in, 6'h15};
    cmp_out = (level >= {1'b0, trial_in});
  end
endmodule : sar_analog_model
`default_nettype wire

// ===== verification/sar_adc_sequencer_test.sv
// Self-checking bench of the converter sequencer and its analog sources.
// Assumes the 10 MHz clock and the one-cycle register port of the design.
`default_nettype none
module sar_adc_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk_in = 1'b0;
  logic        srst_in    = 1'b1;
  logic [2:0]  addr_in    = 3'h0;
  logic [15:0] wdata_in   = 16'h0000;
  logic        wr_in      = 1'b0;
  logic        rd_in      = 1'b0;
  logic        osc_in     = 1'b0;
  logic [3:0]  osc_cnt    = 4'h0;
  logic        cmp_in;
  logic [15:0] rdata_out;
  logic [3:0]  channel_out;
  logic [9:0]  trial_out;
  logic        ref_conn_out;
  logic        sample_out;
  logic        irq_out;
  int          n_fail      = 0;
  int          checks_done = 0;
  localparam logic [15:0] VREF = 16'h0001 << sar_pkg::C1_VREF;
  localparam logic [15:0] R10  = 16'h0001 << sar_pkg::C1_RES10;
  localparam logic [15:0] GRP  = 16'h0001 << sar_pkg::C1_GRP;
  localparam logic [15:0] RPT  = 16'h0001 << sar_pkg::C0_RPT;
  localparam logic [15:0] GO   = 16'h0001 << sar_pkg::C0_START;

  always #50 ref_clk_in = ~ref_clk_in;
  // Free-running oscillator, one rising edge every 12 system cycles
  always @(posedge ref_clk_in) begin
    osc_cnt <= (osc_cnt == 4'h5) ? 4'h0 : osc_cnt + 4'h1;
    if (osc_cnt == 4'h5) osc_in <= ~osc_in;
  end

  sar_adc_sequencer dut_u (
    .ref_clk_in  (ref_clk_in),
    .srst_in     (srst_in),
    .addr_in     (addr_in),
    .wdata_in    (wdata_in),
    .wr_in       (wr_in),
    .rd_in       (rd_in),
    .rdata_out   (rdata_out),
    .osc_in      (osc_in),
    .cmp_in      (cmp_in),
    .channel_out (channel_out),
    .ref_conn_out(ref_conn_out),
    .sample_out  (sample_out),
    .trial_out   (trial_out),
    .irq_out     (irq_out)
  );
  sar_analog_model model_u (
    .channel_in(channel_out),
    .trial_in  (trial_out),
    .cmp_out   (cmp_in)
  );

  task automatic end_sim();
    $display("checks_done %0d n_fail %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp16

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng

  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask : wr_reg

  task automatic chk_reg(input string what, input logic [2:0] a, input logic [15:0] exp);
    @(posedge ref_clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    @(negedge ref_clk_in);
    cmp16(what, exp, rdata_out);
  endtask : chk_reg

  task automatic chk_irq(input logic exp);
    repeat (2) @(negedge ref_clk_in);
    cmp16("irq", {15'h0000, exp}, {15'h0000, irq_out});
  endtask : chk_irq

  // Hold choice and channel go in before start; ladder gets over 1 us to settle
  task automatic start(input logic [15:0] c0, input logic [15:0] c1, input logic [15:0] c2);
    wr_reg(sar_pkg::OFF_CTRL1, c1 | VREF);
    wr_reg(sar_pkg::OFF_CTRL2, c2);
    wr_reg(sar_pkg::OFF_CTRL0, c0);
    repeat (12) @(posedge ref_clk_in);
    wr_reg(sar_pkg::OFF_CTRL0, c0 | GO);
  endtask : start

  task automatic one_shot(input logic [15:0] c0, input logic [15:0] c1, input logic [15:0] c2,
                          input int cyc, input int div, input logic [15:0] res);
    int n;
    n = 0;
    start(c0, c1, c2);
    while (irq_out !== 1'b1 && n < 3000) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk_rng("cycles", cyc * div - div, cyc * div + div + 8, n);
    chk_reg("result", sar_pkg::OFF_RESULT, res);
    chk_reg("ctrl0 done", sar_pkg::OFF_CTRL0, c0);
    wr_reg(sar_pkg::OFF_STAT, 16'h0001);
    chk_irq(1'b0);
  endtask : one_shot

  task automatic count_rises(input int cycles, output int n);
    logic prev;
    n = 0;
    prev = sample_out;
    repeat (cycles) begin
      @(negedge ref_clk_in);
      if (sample_out === 1'b1 && prev !== 1'b1) n++;
      prev = sample_out;
    end
  endtask : count_rises

  task automatic t_idle();
    for (int a = 0; a < 8; a++) begin
      chk_reg("reset value", a[2:0], 16'h0000);
    end
    wr_reg(3'h7, 16'hFFFF);
    chk_reg("unmapped", 3'h7, 16'h0000);
    wr_reg(sar_pkg::OFF_CTRL1, VREF);
    wr_reg(sar_pkg::OFF_CTRL0, 16'h0007);
    repeat (300) @(negedge ref_clk_in);
    cmp16("sample idle", 16'h0000, {15'h0000, sample_out});
    chk_reg("status idle", sar_pkg::OFF_STAT, 16'h0000);
  endtask : t_idle

  task automatic t_lengths();
    int cyc;
    for (int i = 0; i < 4; i++) begin
      cyc = i[0] ? (i[1] ? 33 : 28) : (i[1] ? 59 : 49);
      one_shot(16'h0007, GRP | (i[1] ? R10 : 16'h0000), {15'h0000, i[0]}, cyc, 4,
               i[1] ? 16'h03FF : 16'h00FF);
    end
  endtask : t_lengths

  task automatic t_channels();
    logic [15:0] c0;
    logic [15:0] exp;
    for (int i = 0; i < 12; i++) begin
      c0  = (i < 8) ? i[15:0] : i[15:0] - 16'h0004;
      exp = (i == 11) ? 16'h03FF : {6'h00, i[3:0], 6'h15};
      one_shot(c0, R10 | ((i < 8) ? 16'h0000 : GRP), 16'h0001, 33, 4, exp);
      cmp16("channel", i[15:0], {12'h000, channel_out});
    end
  endtask : t_channels

  task automatic t_abort();
    start(16'h0005, R10, 16'h0000);
    repeat (80) @(negedge ref_clk_in);
    wr_reg(sar_pkg::OFF_CTRL0, 16'h0005);
    repeat (400) @(negedge ref_clk_in);
    chk_reg("result kept", sar_pkg::OFF_RESULT, 16'h03FF);
    chk_reg("status abort", sar_pkg::OFF_STAT, 16'h0000);
  endtask : t_abort

  task automatic t_mask();
    wr_reg(sar_pkg::OFF_MASK, 16'h0000);
    // Input 5, about a third of full scale, in 8-bit mode: code is the top eight ladder bits
    start(16'h0005, 16'h0000, 16'h0001);
    repeat (200) @(negedge ref_clk_in);
    chk_irq(1'b0);
    chk_reg("status set", sar_pkg::OFF_STAT, 16'h0001);
    chk_reg("result 8-bit", sar_pkg::OFF_RESULT, 16'h0055);
    wr_reg(sar_pkg::OFF_MASK, 16'h0001);
    chk_irq(1'b1);
    wr_reg(sar_pkg::OFF_STAT, 16'h0001);
    chk_irq(1'b0);
  endtask : t_mask

  task automatic t_repeat();
    int n;
    wr_reg(sar_pkg::OFF_CTRL0, RPT);
    start(RPT | 16'h0007, GRP, 16'h0001);
    count_rises(700, n);
    chk_rng("repeat runs", 5, 7, n);
    chk_reg("status repeat", sar_pkg::OFF_STAT, 16'h0000);
    chk_reg("ctrl0 repeat", sar_pkg::OFF_CTRL0, RPT | GO | 16'h0007);
    chk_reg("result repeat", sar_pkg::OFF_RESULT, 16'h00FF);
    wr_reg(sar_pkg::OFF_CTRL0, RPT | 16'h0007);
    repeat (200) @(negedge ref_clk_in);
    count_rises(300, n);
    chk_rng("runs after stop", 0, 0, n);
  endtask : t_repeat

  task automatic t_clocks();
    for (int s = 1; s < 4; s++) begin
      one_shot(16'h0007 | (s[15:0] << sar_pkg::C0_CKS_LSB), GRP, 16'h0001, 28,
               (s == 1) ? 8 : ((s == 2) ? 16 : 12), 16'h00FF);
    end
  endtask : t_clocks

  initial begin
    repeat (8) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    t_idle();
    wr_reg(sar_pkg::OFF_MASK, 16'h0001);
    t_lengths();
    t_channels();
    t_abort();
    t_mask();
    t_repeat();
    t_clocks();
    wr_reg(sar_pkg::OFF_CTRL1, 16'h0000);
    @(negedge ref_clk_in);
    cmp16("ladder off", 16'h0000, {15'h0000, ref_conn_out});
    end_sim();
  end

  // Tests need about 6000 cycles; allow five times that
  initial begin
    #3_000_000;
    n_fail++;
    $display("mismatch watchdog expected finish seen hang");
    end_sim();
  end
endmodule : sar_adc_sequencer_test
`default_nettype wire
